/* rtl/gated_frequency_counter.sv */
// gated frequency counter: 16-bit event count over a selectable gate
// assumes START/CLEAR are one-cycle pulses and EXT_COUNT_INPUT is a level
`timescale 1ns/100ps
module gated_frequency_counter (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic EXT_COUNT_INPUT,
  input wire logic START,
  input wire logic CLEAR,
  input wire logic GATE_SHORT,
  input wire logic IRQ_MODE,
  output logic [15:0] RESULT,
  output logic BUSY,
  output logic DONE,
  output logic GATE_IRQ
);
  //////////////////////////////////////////////////////////////////////////////
  // timer tick
  logic [16:0] acc_reg;
  logic [16:0] acc_next;
  logic tick_reg;
  wire logic [16:0] acc_sum = acc_reg + 17'(freq_count_pkg::TICK_ACC_STEP);
  wire logic acc_wrap = acc_sum >= 17'(freq_count_pkg::TICK_ACC_MOD);
  // fractional step keeps the long-run tick rate exact; each tick jitters by half a cycle
  // fractional divider
  assign acc_next = acc_wrap ? 17'(acc_sum - 17'(freq_count_pkg::TICK_ACC_MOD)) : acc_sum;
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      tick_reg <= acc_wrap;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // input synchroniser, sampled only on the tick, as a real timer pin would be
  logic [1:0] sync_reg;
  logic prev_reg;
  // two stages, second one only feeds logic
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      sync_reg <= freq_count_pkg::SYNC_RST;
      prev_reg <= 1'b0;
    end
    else if (tick_reg)
    begin
      sync_reg <= {sync_reg[0], EXT_COUNT_INPUT};
      prev_reg <= sync_reg[1];
    end
  end
  // the gate-opening change is not counted, so a run may read one low
  wire logic in_rise = tick_reg && sync_reg[1] && !prev_reg;
  wire logic in_change = tick_reg && (sync_reg[1] != prev_reg);
  //////////////////////////////////////////////////////////////////////////////
  // control
  freq_count_pkg::state_t state_reg;
  freq_count_pkg::state_t state_next;
  logic [19:0] gate_reg;
  logic [19:0] gate_next;
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic irq_reg;
  logic irq_mode_reg;
  // gate length is loaded once, so the select pin may move mid-gate
  // gate length chosen at start
  wire logic [19:0] gate_load = GATE_SHORT ? 20'(freq_count_pkg::GATE_TICKS_SHORT)
                                           : 20'(freq_count_pkg::GATE_TICKS_LONG);
  // last tick of the gate; a rise sampled on it still counts
  wire logic gate_end = (state_reg == freq_count_pkg::ST_GATE) && tick_reg && (gate_reg == 20'h1);
  wire logic [15:0] count_inc = (count_reg == freq_count_pkg::COUNT_MAX) ? count_reg
                                                                          : 16'(count_reg + 16'h1);
  always_comb
  begin
    state_next = state_reg;
    gate_next = gate_reg;
    count_next = count_reg;
    result_next = result_reg;
    unique case (state_reg)
      freq_count_pkg::ST_IDLE:
      begin
        if (START)
        begin
          state_next = freq_count_pkg::ST_ARMED;
          gate_next = gate_load;
          count_next = '0;
        end
      end
      freq_count_pkg::ST_ARMED:
      begin
        // limitation: with a dead input only a reset leaves this state
        // wait for first level change
        if (in_change)
          state_next = freq_count_pkg::ST_GATE;
      end
      freq_count_pkg::ST_GATE:
      begin
        if (in_rise)
          count_next = count_inc;
        if (tick_reg)
          gate_next = 20'(gate_reg - 20'h1);
        // overflow code falls out of saturation
        if (gate_end)
        begin
          state_next = freq_count_pkg::ST_DONE;
          result_next = (in_rise ? count_inc : count_reg);
        end
      end
      freq_count_pkg::ST_DONE:
      begin
        // clear frees the result for the next run
        if (CLEAR)
        begin
          state_next = freq_count_pkg::ST_IDLE;
          result_next = freq_count_pkg::RESULT_RST;
        end
      end
    endcase
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      state_reg <= freq_count_pkg::ST_IDLE;
      gate_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      gate_reg <= gate_next;
    end
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      count_reg <= '0;
      result_reg <= freq_count_pkg::RESULT_RST;
    end
    else
    begin
      count_reg <= count_next;
      // full-width result, zero until done, held until cleared
      result_reg <= result_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // gate expiry event
  // a start is taken only from idle
  wire logic start_take = START && (state_reg == freq_count_pkg::ST_IDLE);
  wire logic irq_next = gate_end && irq_mode_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      irq_reg <= 1'b0;
      irq_mode_reg <= 1'b0;
    end
    else
    begin
      // mode is latched so a pin change mid-gate cannot lose or fake the pulse
      if (start_take)
        irq_mode_reg <= IRQ_MODE;
      irq_reg <= irq_next;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // outputs; busy covers the whole wait a polled caller sits through
  logic busy_reg;
  logic done_reg;
  logic [15:0] out_reg;
  // busy from start until gate fully elapsed
  wire logic busy_next = (state_next == freq_count_pkg::ST_ARMED)
    || (state_next == freq_count_pkg::ST_GATE);
  wire logic done_next = state_next == freq_count_pkg::ST_DONE;
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      out_reg <= freq_count_pkg::RESULT_RST;
    end
    else
    begin
      busy_reg <= busy_next;
      done_reg <= done_next;
      out_reg <= result_next;
    end
  end
  // ports straight from flip-flops, no logic after the registers
  assign RESULT = out_reg;
  assign BUSY = busy_reg;
  assign DONE = done_reg;
  assign GATE_IRQ = irq_reg;
endmodule // gated_frequency_counter

/* rtl/freq_count_pkg.sv */
// constants for the gated frequency counter
// assumes a 100 MHz system clock and an 8 MHz timer tick made inside the block
package freq_count_pkg;
  localparam int unsigned SYS_CLK_HZ = 100000000;
  localparam int unsigned TIMER_CLK_HZ = 8000000;
  // timer tick enable: 100 MHz / 8 MHz = 12.5, so the divider alternates 12 and 13
  localparam int unsigned TICK_ACC_STEP = TIMER_CLK_HZ / 1000;
  localparam int unsigned TICK_ACC_MOD = SYS_CLK_HZ / 1000;
  localparam int unsigned TICK_ACC_W = 17;
  localparam int unsigned GATE_MS_LONG = 100;
  localparam int unsigned GATE_MS_SHORT = 1;
  localparam int unsigned GATE_TICKS_LONG = GATE_MS_LONG * (TIMER_CLK_HZ / 1000);
  localparam int unsigned GATE_TICKS_SHORT = GATE_MS_SHORT * (TIMER_CLK_HZ / 1000);
  localparam int unsigned GATE_W = 20;
  localparam int unsigned COUNT_W = 16;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [1:0] SYNC_RST = 2'h0;
  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_GATE, ST_DONE} state_t;
endpackage

/* tb/freq_count_monitor.sv */
// port checker for the gated frequency counter
// assumes it is bound onto gated_frequency_counter
`timescale 1ns/100ps
module freq_count_monitor (
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic START,
  input wire logic CLEAR,
  input wire logic IRQ_MODE,
  input wire logic [15:0] RESULT,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic GATE_IRQ
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  // mode as taken with an accepted start
  logic irq_mode_seen_reg;
  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
      irq_mode_seen_reg <= 1'b0;
    else if (START && !BUSY && !DONE)
      irq_mode_seen_reg <= IRQ_MODE;
  end
  sequence s_clear;
    DONE && CLEAR;
  endsequence
  sequence s_idle_start;
    START && !BUSY && !DONE;
  endsequence
  chk_start_arms: assert property (s_idle_start |=> BUSY)
    else $error("busy missing after start");
  chk_busy_ends_done: assert property ($fell(BUSY) |-> DONE)
    else $error("busy fell without done");
  chk_never_both: assert property (!(BUSY && DONE))
    else $error("busy and done together");
  chk_result_zero: assert property (BUSY |-> RESULT == 16'h0000)
    else $error("result not zero while measuring");
  chk_result_held: assert property (DONE && !CLEAR |=> DONE && $stable(RESULT))
    else $error("result moved before clear");
  chk_clear_result: assert property (s_clear |=> !DONE && RESULT == 16'h0000)
    else $error("clear did not reset result");
  chk_irq_at_done: assert property (GATE_IRQ |-> $rose(DONE))
    else $error("irq not at gate end");
  chk_irq_one_cycle: assert property (GATE_IRQ |=> !GATE_IRQ)
    else $error("irq longer than one cycle");
  chk_done_raises_irq: assert property ($rose(DONE) && irq_mode_seen_reg |-> GATE_IRQ)
    else $error("no irq at gate end in irq mode");
  chk_polled_no_irq: assert property (GATE_IRQ |-> irq_mode_seen_reg)
    else $error("irq pulsed in polled mode");
endmodule // freq_count_monitor
bind gated_frequency_counter freq_count_monitor i_mon (.SYS_CLK, .NRST, .START, .CLEAR,
  .IRQ_MODE, .RESULT, .BUSY, .DONE, .GATE_IRQ);

/* tb/sig_source.sv */
// square wave source on the counted input
// assumes the bench sets the half period in system cycles
`timescale 1ns/100ps
module sig_source (
  input wire logic SYS_CLK,
  input wire logic [31:0] half_cyc,
  output logic wave = 1'b0
);
  int cnt = 0;
  // bench keeps half period at 16 cycles or more
  always @(negedge SYS_CLK)
  begin
    if (cnt >= int'(half_cyc) - 1)
    begin
      cnt <= 0;
      wave <= !wave;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // sig_source

/* tb/tb_top.sv */
// bench: one short-gate irq measurement at a random rate
// assumes the source model and the bound checker
`timescale 1ns/100ps
module tb_top;
  logic SYS_CLK = 1'b0, NRST = 1'b0, START = 1'b0, CLEAR = 1'b0, BUSY, DONE, GATE_IRQ, ext_in;
  logic GATE_SHORT = 1'b1, IRQ_MODE = 1'b1;
  logic [15:0] RESULT, exp_cnt;
  logic [31:0] lfsr = 32'h5A413FAF;
  int miscompares = 0, n_tests = 0, half_cyc = 50;
  always #5 SYS_CLK = !SYS_CLK;
  sig_source i_src (.SYS_CLK, .half_cyc, .wave(ext_in));
  gated_frequency_counter i_dut (.SYS_CLK, .NRST, .EXT_COUNT_INPUT(ext_in), .START, .CLEAR,
    .GATE_SHORT, .IRQ_MODE, .RESULT, .BUSY, .DONE, .GATE_IRQ);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // short gate length in system cycles, one count per period of 2*h cycles
  function automatic logic [15:0] count_for(input int h);
    return 16'(freq_count_pkg::GATE_MS_SHORT * (freq_count_pkg::SYS_CLK_HZ / 1000) / (2 * h));
  endfunction
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // sync edge jitter allows the count to miss by two
  task automatic check_count;
    n_tests++;
    if ((16'(RESULT + 16'h0002 - exp_cnt) <= 16'h0004) !== 1'b1)
    begin
      miscompares++;
      $display("Error count expected %h seen %h", exp_cnt, RESULT);
    end
  endtask
  initial
  begin
    repeat (130000) @(posedge SYS_CLK);
    miscompares++;
    wrap_up();
  end
  initial
  begin
    repeat (12) @(negedge SYS_CLK);
    NRST = 1'b1;
    check("idle result", 16'h0000, RESULT);
    // polled long gate: only its opening fits the run, then a reset cuts it
    GATE_SHORT = 1'b0;
    IRQ_MODE = 1'b0;
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    repeat (400) @(negedge SYS_CLK);
    check("polled busy", 16'h0001, {15'h0000, BUSY});
    check("polled done", 16'h0000, {15'h0000, DONE});
    check("polled irq", 16'h0000, {15'h0000, GATE_IRQ});
    check("polled result", 16'h0000, RESULT);
    NRST = 1'b0;
    repeat (3) @(negedge SYS_CLK);
    check("reset busy", 16'h0000, {15'h0000, BUSY});
    NRST = 1'b1;
    $display("test polled start finished");
    GATE_SHORT = 1'b1;
    IRQ_MODE = 1'b1;
    lfsr = lfsr_next(lfsr);
    half_cyc = 16 + lfsr[5:0];
    exp_cnt = count_for(half_cyc);
    START = 1'b1;
    @(negedge SYS_CLK);
    CLEAR = 1'b1;
    check("busy", 16'h0001, {15'h0000, BUSY});
    check("result measuring", 16'h0000, RESULT);
    @(negedge SYS_CLK);
    START = 1'b0;
    CLEAR = 1'b0;
    for (int i = 0; i < 120000 && DONE !== 1'b1; i++) @(negedge SYS_CLK);
    check("gate irq", 16'h0001, {15'h0000, GATE_IRQ});
    check_count();
    START = 1'b1;
    repeat (20) @(negedge SYS_CLK);
    START = 1'b0;
    check("done held", 16'h0001, {15'h0000, DONE});
    check_count();
    CLEAR = 1'b1;
    @(negedge SYS_CLK);
    CLEAR = 1'b0;
    check("cleared done", 16'h0000, {15'h0000, DONE});
    check("cleared result", 16'h0000, RESULT);
    $display("test short gate irq finished");
    // back-to-back start straight after the clear
    IRQ_MODE = 1'b0;
    START = 1'b1;
    @(negedge SYS_CLK);
    START = 1'b0;
    check("restart busy", 16'h0001, {15'h0000, BUSY});
    check("restart result", 16'h0000, RESULT);
    $display("test restart finished");
    wrap_up();
  end
endmodule // tb_top
